// >>> src/sys_clock_select.v
// Notes on behaviour
// - frequency code picks fast divide or slow
// - frequency code resets to 4 MHz code
// - running flag shows external clock in use
// - running flag resets high
// - fast stable flag tracks warm-up, resets low
// - slow stable flag tracks warm-up, resets low
// - pick bit routes internal clock, resets low
// - top control bit always reads zero
// - crystal start-up counts 1024 input edges
// - start-up runs after wake; at power-up the reset config (external clock, timer off) goes straight to run
// - processor held during crystal start-up unless two-speed or pick bit runs it on internal clock
// - internal oscillator warm-up before use
// - external clock mode skips start-up count
// - external clock frees second oscillator pin
// - fully static, stopped clock keeps state
// - crystal mode sets amplifier gain level
// - fast and slow internal sources provided
// - switch waits fall, holds low, joins rise
// - slow oscillator enabled by listed conditions
`timescale 1ns/1ps
`include "clk_ctrl_defs.vh"

module sys_clock_select #(
    parameter ADDR_W    = 4,
    parameter OST_COUNT = `OST_EDGES,
    parameter WARM_CNT  = `WARM_CYCLES
) (
    // clock and reset
    input  wire              i_core_clk,
    input  wire              i_rst_n,
    // register port
    input  wire [ADDR_W-1:0] i_addr,
    input  wire [7:0]        i_wdata,
    input  wire              i_wr,
    input  wire              i_rd,
    output reg  [7:0]        o_rdata,
    // oscillator levels, sampled
    input  wire              i_osc1,
    input  wire              i_fast_osc,
    input  wire              i_slow_osc,
    // power events
    input  wire              i_powerup_timer_expired,
    input  wire              i_sleep,
    input  wire              i_wake,
    // clock and control outputs
    output reg               o_sys_clk,
    output reg               o_cpu_hold,
    output reg  [1:0]        o_gain,
    output reg               o_osc2_gpio,
    output reg               o_fast_osc_en,
    output reg               o_slow_osc_en
);

    // ---------------------------------------------------------------
    // state codes
    // ---------------------------------------------------------------
    localparam ST_POWERUP_TIMER  = 2'h0;
    localparam ST_OST   = 2'h1;
    localparam ST_RUN   = 2'h2;
    localparam ST_SLEEP = 2'h3;

    localparam [10:0] OST_LAST  = OST_COUNT - 1;
    localparam [15:0] WARM_LAST = WARM_CNT;

    // ---------------------------------------------------------------
    // decode helpers
    // ---------------------------------------------------------------
    function is_crystal;
        input [2:0] mode;
        begin
            is_crystal = (mode == `MODE_LOW_GAIN) ||
                         (mode == `MODE_MID_GAIN) ||
                         (mode == `MODE_HIGH_GAIN);
        end
    endfunction

    function is_internal;
        input [2:0] mode;
        begin
            is_internal = (mode == `MODE_INT_IO) ||
                          (mode == `MODE_INT_CLKOUT);
        end
    endfunction

    function ext_flag_reset;
        input [7:0] cfg;
        begin
            ext_flag_reset = ~(cfg[`CF_FAIL_SAFE] |
                (cfg[`CF_TWO_SPEED] &
                 is_crystal(cfg[`CF_MODE_HI:`CF_MODE_LO])));
        end
    endfunction

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    reg  [2:0]  ifs_q;
    reg         pick_q;
    reg  [7:0]  cfg_q;
    reg         ext_flag_q;
    reg  [1:0]  state_q;
    reg         por_q;
    reg  [10:0] ost_cnt_q;
    reg         osc1_prev_q;
    reg         fast_prev_q;
    reg  [6:0]  post_cnt_q;
    reg         fast_div_q;
    wire [1:0]  stable;
    wire [1:0]  osc_en;

    wire [2:0] mode      = cfg_q[`CF_MODE_HI:`CF_MODE_LO];
    wire       two_speed = cfg_q[`CF_TWO_SPEED];
    wire       crystal   = is_crystal(mode);
    wire       ext_ready = (state_q == ST_RUN);
    wire       asleep    = (state_q == ST_SLEEP);

    // ---------------------------------------------------------------
    // source choice
    // ---------------------------------------------------------------
    // pick routes internal clock
    wire use_int = pick_q | is_internal(mode) |
                   (two_speed & crystal & ~ext_ready);
    wire want_slow = (ifs_q == `IFS_SLOW);
    wire [1:0] target = !use_int  ? `SRC_EXT :
                        want_slow ? `SRC_SLOW : `SRC_FAST;
    wire target_stable = want_slow ? stable[1] : stable[0];

    wire slow_need = (want_slow & use_int & ~asleep) |
                     cfg_q[`CF_POWERUP_TIMER_EN] | cfg_q[`CF_WDT_EN] |
                     cfg_q[`CF_FAIL_SAFE];
    // fast source for codes above zero
    wire fast_need = ~want_slow & ~asleep &
                     (use_int | two_speed);

    assign osc_en = {slow_need, fast_need};

    // ---------------------------------------------------------------
    // warm-up timers
    // ---------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : warm
            reg [15:0] cnt_q;
            always @(posedge i_core_clk) begin
                if (!i_rst_n || !osc_en[g]) begin
                    cnt_q <= 16'h0000;
                end else if (cnt_q != WARM_LAST) begin
                    cnt_q <= cnt_q + 16'h0001;
                end
            end
            assign stable[g] = (cnt_q == WARM_LAST);
        end
    endgenerate

    // ---------------------------------------------------------------
    // fast postscaler
    // ---------------------------------------------------------------
    wire fast_rise = i_fast_osc & ~fast_prev_q;
    wire [2:0] shift_sel = `IFS_FAST_MAX - ifs_q - 3'h1;
    wire [6:0] post_mask = (7'h01 << shift_sel) - 7'h01;

    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            fast_prev_q <= 1'b0;
            post_cnt_q  <= 7'h00;
            fast_div_q  <= 1'b0;
        end else begin
            fast_prev_q <= i_fast_osc;
            if (ifs_q == `IFS_FAST_MAX) begin
                fast_div_q <= i_fast_osc;
            end else if (fast_rise) begin
                if ((post_cnt_q & post_mask) == post_mask) begin
                    post_cnt_q <= 7'h00;
                    fast_div_q <= ~fast_div_q;
                end else begin
                    post_cnt_q <= post_cnt_q + 7'h01;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // start-up sequencer
    // ---------------------------------------------------------------
    wire osc1_rise = i_osc1 & ~osc1_prev_q;

    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            state_q     <= ST_POWERUP_TIMER;
            por_q       <= 1'b1;
            ost_cnt_q   <= 11'h000;
            osc1_prev_q <= 1'b0;
        end else begin
            osc1_prev_q <= i_osc1;
            case (state_q)
                ST_POWERUP_TIMER: begin
                    if (!cfg_q[`CF_POWERUP_TIMER_EN] || i_powerup_timer_expired) begin
                        por_q     <= 1'b0;
                        ost_cnt_q <= 11'h000;
                        state_q   <= crystal ? ST_OST : ST_RUN;
                    end
                end
                ST_OST: begin
                    if (i_sleep) begin
                        state_q <= ST_SLEEP;
                    end else if (!crystal) begin
                        state_q <= ST_RUN;
                    end else if (osc1_rise) begin
                        if (ost_cnt_q == OST_LAST) begin
                            state_q <= ST_RUN;
                        end else begin
                            ost_cnt_q <= ost_cnt_q + 11'h001;
                        end
                    end
                end
                ST_RUN: begin
                    if (i_sleep) begin
                        state_q <= ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (i_wake) begin
                        ost_cnt_q <= 11'h000;
                        state_q   <= crystal ? ST_OST : ST_RUN;
                    end
                end
                default: begin
                    state_q <= ST_POWERUP_TIMER;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // clock switch
    // ---------------------------------------------------------------
    wire       sw_clk;
    wire [1:0] sw_src;
    reg  [1:0] sw_target;

    glitchless_clock_switch u_switch (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_src      ({i_slow_osc, fast_div_q, i_osc1}),
        .i_target   (sw_target),
        .o_clk_out  (sw_clk),
        .o_cur_src  (sw_src),
        .o_busy     ()
    );

    always @* begin
        sw_target = sw_src;
        if (target == `SRC_EXT) begin
            if (ext_ready) begin
                sw_target = `SRC_EXT;
            end
        end else if (target_stable) begin
            sw_target = target;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_sys_clk     <= 1'b0;
            o_cpu_hold    <= 1'b1;
            o_gain        <= `GAIN_OFF;
            o_osc2_gpio   <= 1'b0;
            o_fast_osc_en <= 1'b0;
            o_slow_osc_en <= 1'b0;
            ext_flag_q    <= ext_flag_reset(`CFG_RESET);
        end else begin
            o_sys_clk     <= sw_clk;
            o_cpu_hold    <= asleep || (state_q == ST_POWERUP_TIMER) ||
                             (use_int ? !target_stable : !ext_ready);
            case (mode)
                `MODE_LOW_GAIN:  o_gain <= `GAIN_LOW;
                `MODE_MID_GAIN:  o_gain <= `GAIN_MID;
                `MODE_HIGH_GAIN: o_gain <= `GAIN_HIGH;
                default:         o_gain <= `GAIN_OFF;
            endcase
            o_osc2_gpio   <= (mode == `MODE_EXT_CLOCK) ||
                             (mode == `MODE_INT_IO) ||
                             (mode == `MODE_RC_IO);
            o_fast_osc_en <= fast_need;
            o_slow_osc_en <= slow_need;
            ext_flag_q    <= (sw_src == `SRC_EXT) &&
                             !is_internal(mode);
        end
    end

    // ---------------------------------------------------------------
    // register port
    // ---------------------------------------------------------------
    wire [7:0] osc_ctrl_rd = {1'b0, ifs_q, ext_flag_q,
                              stable[0], stable[1], pick_q};
    wire [7:0] status_rd   = {2'h0, o_osc2_gpio, o_cpu_hold,
                              sw_src, state_q};

    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            ifs_q   <= `IFS_RESET;
            pick_q  <= 1'b0;
            cfg_q   <= `CFG_RESET;
            o_rdata <= 8'h00;
        end else begin
            if (i_wr) begin
                if (i_addr == `OFS_OSC_CTRL) begin
                    ifs_q  <= i_wdata[`OC_IFS_HI:`OC_IFS_LO];
                    pick_q <= i_wdata[`OC_PICK];
                end else if (i_addr == `OFS_CONFIG) begin
                    cfg_q  <= {1'b0, i_wdata[6:0]};
                end
            end
            o_rdata <= 8'h00;
            if (i_rd) begin
                if (i_addr == `OFS_OSC_CTRL) begin
                    o_rdata <= osc_ctrl_rd;
                end else if (i_addr == `OFS_CONFIG) begin
                    o_rdata <= cfg_q;
                end else if (i_addr == `OFS_STATUS) begin
                    o_rdata <= status_rd;
                end
            end
        end
    end

endmodule

// >>> src/clk_ctrl_defs.vh
`ifndef CLK_CTRL_DEFS_VH
`define CLK_CTRL_DEFS_VH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define OFS_OSC_CTRL     4'h0
`define OFS_CONFIG       4'h1
`define OFS_STATUS       4'h2

// ---------------------------------------------------------------
// oscillator_control fields
// ---------------------------------------------------------------
`define OC_IFS_HI        6
`define OC_IFS_LO        4
`define OC_EXT_RUN       3
`define OC_HF_STABLE     2
`define OC_LF_STABLE     1
`define OC_PICK          0
`define IFS_RESET        3'h6
`define IFS_SLOW         3'h0
`define IFS_FAST_MAX     3'h7

// ---------------------------------------------------------------
// config_word_one fields
// ---------------------------------------------------------------
`define CF_MODE_HI       2
`define CF_MODE_LO       0
`define CF_TWO_SPEED     3
`define CF_FAIL_SAFE     4
`define CF_POWERUP_TIMER_EN       5
`define CF_WDT_EN        6
`define CFG_RESET        8'h03

// ---------------------------------------------------------------
// clock source modes
// ---------------------------------------------------------------
`define MODE_LOW_GAIN    3'h0
`define MODE_MID_GAIN    3'h1
`define MODE_HIGH_GAIN   3'h2
`define MODE_EXT_CLOCK   3'h3
`define MODE_INT_IO      3'h4
`define MODE_INT_CLKOUT  3'h5
`define MODE_RC_IO       3'h6
`define MODE_RC          3'h7

// ---------------------------------------------------------------
// gain settings
// ---------------------------------------------------------------
`define GAIN_OFF         2'h0
`define GAIN_LOW         2'h1
`define GAIN_MID         2'h2
`define GAIN_HIGH        2'h3

// ---------------------------------------------------------------
// switch source indices
// ---------------------------------------------------------------
`define SRC_EXT          2'h0
`define SRC_FAST         2'h1
`define SRC_SLOW         2'h2

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CORE_CLK_MHZ     100
`define OST_EDGES        1024
`define WARM_TIME_NS     2000
`define WARM_CYCLES      ((`WARM_TIME_NS * `CORE_CLK_MHZ + 999) / 1000)

`endif

// >>> src/glitchless_clock_switch.v
`timescale 1ns/1ps
`include "clk_ctrl_defs.vh"

module glitchless_clock_switch (
    // clock and reset
    input  wire       i_core_clk,
    input  wire       i_rst_n,
    // source levels and target
    input  wire [2:0] i_src,
    input  wire [1:0] i_target,
    // switched clock
    output reg        o_clk_out,
    output reg  [1:0] o_cur_src,
    output reg        o_busy
);

    localparam SW_RUN       = 2'h0;
    localparam SW_WAIT_FALL = 2'h1;
    localparam SW_WAIT_RISE = 2'h2;

    reg [1:0] state_q;
    reg [1:0] next_src_q;
    reg [2:0] src_prev_q;

    wire cur_lvl  = i_src[o_cur_src];
    wire cur_fell = src_prev_q[o_cur_src] & ~cur_lvl;
    wire new_rose = ~src_prev_q[next_src_q] & i_src[next_src_q];

    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            state_q    <= SW_RUN;
            next_src_q <= `SRC_EXT;
            src_prev_q <= 3'h0;
            o_clk_out  <= 1'b0;
            o_cur_src  <= `SRC_EXT;
            o_busy     <= 1'b0;
        end else begin
            src_prev_q <= i_src;
            case (state_q)
                SW_RUN: begin
                    o_clk_out <= cur_lvl;
                    if (i_target != o_cur_src) begin
                        next_src_q <= i_target;
                        state_q    <= SW_WAIT_FALL;
                        o_busy     <= 1'b1;
                    end
                end
                SW_WAIT_FALL: begin
                    o_clk_out <= cur_lvl;
                    if (cur_fell) begin
                        o_clk_out <= 1'b0;
                        state_q   <= SW_WAIT_RISE;
                    end
                end
                SW_WAIT_RISE: begin
                    o_clk_out <= 1'b0;
                    if (new_rose) begin
                        o_clk_out <= 1'b1;
                        o_cur_src <= next_src_q;
                        state_q   <= SW_RUN;
                        o_busy    <= 1'b0;
                    end
                end
                default: begin
                    state_q <= SW_RUN;
                end
            endcase
        end
    end

endmodule

// >>> sim/osc_source_model.sv
`timescale 1ns/1ps

module osc_source_model (
    // core clock and crystal run control
    input  wire i_core_clk,
    input  wire i_ext_run,
    // oscillator levels
    output reg  o_osc1,
    output reg  o_fast_osc,
    output reg  o_slow_osc
);
reg [3:0] phase_q;

initial begin
    phase_q    = 4'h0;
    o_osc1     = 1'b0;
    o_fast_osc = 1'b0;
    o_slow_osc = 1'b0;
end

// fast toggles each cycle, crystal every 4, slow every 8
always @(posedge i_core_clk) begin
    phase_q    <= phase_q + 4'h1;
    o_fast_osc <= phase_q[0];
    o_slow_osc <= phase_q[3];
    if (i_ext_run) begin
        o_osc1 <= phase_q[2];
    end
end
endmodule

// >>> sim/sys_clock_select_asserts.sv
`timescale 1ns/1ps

module sys_clock_select_asserts #(
    parameter ADDR_W    = 4,
    parameter OST_COUNT = 1024,
    parameter WARM_CNT  = 200
) (
    input wire              i_core_clk,
    input wire              i_rst_n,
    input wire [ADDR_W-1:0] i_addr,
    input wire              i_wr,
    input wire              i_rd,
    input wire [7:0]        o_rdata,
    input wire              i_osc1,
    input wire              i_fast_osc,
    input wire              i_slow_osc,
    input wire              o_sys_clk,
    input wire [1:0]        o_gain,
    input wire              o_osc2_gpio,
    input wire              o_fast_osc_en,
    input wire              o_slow_osc_en
);
// ----------
// cycles since reset and since the last source edge
// ----------
reg  [2:0] src_q;
reg  [3:0] up_q;
reg  [3:0] rise_q;
reg  [3:0] chg_q;
wire [2:0] src    = {i_osc1, i_fast_osc, i_slow_osc};
wire       cfg_wr = i_wr && (i_addr == ADDR_W'(1));

always @(posedge i_core_clk) begin
    src_q <= src;
    if (!i_rst_n) begin
        up_q   <= 4'h0;
        rise_q <= 4'hF;
        chg_q  <= 4'hF;
    end else begin
        up_q   <= (up_q == 4'hF) ? up_q : up_q + 4'h1;
        rise_q <= |(src & ~src_q) ? 4'h0 :
                  (rise_q == 4'hF) ? rise_q : rise_q + 4'h1;
        chg_q  <= (src != src_q) ? 4'h0 :
                  (chg_q == 4'hF) ? chg_q : chg_q + 4'h1;
    end
end

default clocking cb @(posedge i_core_clk); endclocking
default disable iff (!i_rst_n);

top_bit_zero_a: assert property (o_rdata[7] == 1'b0)
    else $error("read data bit 7 set");
hf_flag_en_a: assert property (
    $past(i_rd) && $past(i_addr) == 0 && o_rdata[2]
    |-> $past(o_fast_osc_en) || $past(o_fast_osc_en, 2))
    else $error("fast stable flag without enable");
lf_flag_en_a: assert property (
    $past(i_rd) && $past(i_addr) == 0 && o_rdata[1]
    |-> $past(o_slow_osc_en) || $past(o_slow_osc_en, 2))
    else $error("slow stable flag without enable");
clk_static_a: assert property (
    $changed(o_sys_clk) |-> chg_q < 4'h6)
    else $error("system clock moved with sources still");
clk_rise_src_a: assert property (
    $rose(o_sys_clk) |-> rise_q < 4'h6)
    else $error("system clock rose without a source rise");
gain_pin_a: assert property (
    o_gain != 2'h0 && $past(o_gain) != 2'h0 |-> !o_osc2_gpio)
    else $error("second pin freed while amplifier on");
pin_on_cfg_a: assert property (
    up_q > 4'h3 && $changed(o_osc2_gpio)
    |-> $past(cfg_wr) || $past(cfg_wr, 2) || $past(cfg_wr, 3))
    else $error("second pin use changed without config write");
unmapped_read_a: assert property (
    $past(i_rd) && $past(i_addr) > 2 |-> o_rdata == 8'h00)
    else $error("unmapped read returned data");
endmodule

bind sys_clock_select sys_clock_select_asserts #(
    .ADDR_W(ADDR_W), .OST_COUNT(OST_COUNT), .WARM_CNT(WARM_CNT)
) i_sys_clock_select_asserts (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_osc1(i_osc1),
    .i_fast_osc(i_fast_osc), .i_slow_osc(i_slow_osc),
    .o_sys_clk(o_sys_clk), .o_gain(o_gain), .o_osc2_gpio(o_osc2_gpio),
    .o_fast_osc_en(o_fast_osc_en), .o_slow_osc_en(o_slow_osc_en)
);

// >>> sim/test_sys_clock_select.sv
`timescale 1ns/1ps
`include "clk_ctrl_defs.vh"

module test_sys_clock_select;
localparam [7:0] OST_N = 8'h08;
reg        i_core_clk, i_rst_n, i_wr, i_rd, ext_run, prev;
reg        i_powerup_timer_expired, i_sleep, i_wake;
reg  [3:0] i_addr;
reg  [7:0] i_wdata;
wire [7:0] o_rdata;
wire [1:0] o_gain;
wire       i_osc1, i_fast_osc, i_slow_osc, o_sys_clk, o_cpu_hold;
wire       o_osc2_gpio, o_fast_osc_en, o_slow_osc_en;
integer    fail_count, compares, m, n, k;

sys_clock_select #(.OST_COUNT(OST_N), .WARM_CNT(4)) i_sys_clock_select (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_osc1(i_osc1), .i_fast_osc(i_fast_osc), .i_slow_osc(i_slow_osc),
    .i_powerup_timer_expired(i_powerup_timer_expired), .i_sleep(i_sleep), .i_wake(i_wake),
    .o_sys_clk(o_sys_clk), .o_cpu_hold(o_cpu_hold), .o_gain(o_gain),
    .o_osc2_gpio(o_osc2_gpio), .o_fast_osc_en(o_fast_osc_en),
    .o_slow_osc_en(o_slow_osc_en));
osc_source_model i_osc_source_model (
    .i_core_clk(i_core_clk), .i_ext_run(ext_run), .o_osc1(i_osc1),
    .o_fast_osc(i_fast_osc), .o_slow_osc(i_slow_osc));

initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
end
// ----------
// access and compare tasks
// ----------
task automatic check(input [7:0] seen, input [7:0] exp);
    begin
        compares = compares + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end
endtask
// strobes drop for a cycle so back-to-back calls never double-drive
task automatic wr(input [3:0] a, input [7:0] d);
    begin
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
        @(posedge i_core_clk);
    end
endtask
task automatic rd(input [3:0] a, input [7:0] e);
    begin
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1 check(o_rdata, e);
        @(posedge i_core_clk);
    end
endtask
task close_out;
    begin
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
endtask

initial begin
    repeat (20000) @(posedge i_core_clk);
    fail_count = fail_count + 1;
    close_out;
end

initial begin
    fail_count = 0;
    compares = 0;
    {i_rst_n, i_wr, i_rd, i_sleep, i_wake} = 5'h00;
    i_addr = 4'h0;
    i_wdata = 8'h00;
    i_powerup_timer_expired = 1'b1;
    ext_run = 1'b1;
    repeat (20) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    rd(`OFS_OSC_CTRL, 8'h68);
    rd(`OFS_STATUS, 8'h22);
    #1 check(o_osc2_gpio, 8'h01);
    check(o_cpu_hold, 8'h00);
    wr(`OFS_OSC_CTRL, 8'h8E);
    rd(`OFS_OSC_CTRL, 8'h08);
    for (m = 3; m < 16; m = m + 1) begin
        wr(m[3:0], 8'hFF);
        rd(m[3:0], 8'h00);
    end
    rd(`OFS_CONFIG, `CFG_RESET);
    wr(`OFS_CONFIG, {5'h00, `MODE_RC_IO});
    repeat (2) @(posedge i_core_clk);
    #1 check(o_gain, {6'h00, `GAIN_OFF});
    check(o_osc2_gpio, 8'h01);
    $display("register test done");
    for (m = 0; m < 3; m = m + 1) begin
        wr(`OFS_CONFIG, m[7:0]);
        repeat (2) @(posedge i_core_clk);
        #1 check(o_gain, m[7:0] + 8'h01);
        check(o_osc2_gpio, 8'h00);
    end
    $display("gain test done");
    i_sleep <= 1'b1;
    @(posedge i_core_clk);
    i_sleep <= 1'b0;
    // wake well clear of a crystal edge so both sides count alike
    @(posedge i_osc1);
    @(posedge i_core_clk);
    i_wake <= 1'b1;
    @(posedge i_core_clk);
    i_wake <= 1'b0;
    n = 0;
    k = 0;
    prev = i_osc1;
    while ((o_cpu_hold === 1'b1 || k < 4) && k < 400) begin
        @(posedge i_core_clk);
        if (i_osc1 && !prev)
            n = n + 1;
        prev = i_osc1;
        k = k + 1;
    end
    check(n[7:0], OST_N);
    #1 check(o_cpu_hold, 8'h00);
    wr(`OFS_CONFIG, {5'h00, `MODE_EXT_CLOCK});
    ext_run <= 1'b0;
    i_sleep <= 1'b1;
    @(posedge i_core_clk);
    i_sleep <= 1'b0;
    @(posedge i_core_clk);
    i_wake <= 1'b1;
    @(posedge i_core_clk);
    i_wake <= 1'b0;
    repeat (4) @(posedge i_core_clk);
    #1 check(o_cpu_hold, 8'h00);
    prev = o_sys_clk;
    repeat (20) @(posedge i_core_clk);
    #1 check(o_sys_clk, {7'h00, prev});
    $display("start-up test done");
    ext_run <= 1'b1;
    wr(`OFS_OSC_CTRL, 8'hF1);
    repeat (40) @(posedge i_core_clk);
    rd(`OFS_OSC_CTRL, 8'h75);
    #1 prev = o_sys_clk;
    @(posedge i_core_clk);
    #1 check(o_sys_clk, {7'h00, ~prev});
    check(o_fast_osc_en, 8'h01);
    // code 110 must toggle on every fast rise, i.e. every two cycles here
    wr(`OFS_OSC_CTRL, 8'hE1);
    repeat (6) @(posedge i_core_clk);
    #1 prev = o_sys_clk;
    repeat (2) @(posedge i_core_clk);
    #1 check(o_sys_clk, {7'h00, ~prev});
    prev = o_sys_clk;
    repeat (2) @(posedge i_core_clk);
    #1 check(o_sys_clk, {7'h00, ~prev});
    wr(`OFS_OSC_CTRL, 8'h01);
    repeat (60) @(posedge i_core_clk);
    rd(`OFS_OSC_CTRL, 8'h03);
    #1 check(o_slow_osc_en, 8'h01);
    check(o_fast_osc_en, 8'h00);
    wr(`OFS_OSC_CTRL, 8'h60);
    wr(`OFS_CONFIG, 8'h23);
    repeat (40) @(posedge i_core_clk);
    rd(`OFS_OSC_CTRL, 8'h6A);
    #1 check(o_slow_osc_en, 8'h01);
    $display("switch test done");
    close_out;
end
endmodule
